//--- tasv_pkg.sv
// Constants shared by the touch converter serial sequencer
package tasv_pkg;

  // ==========================================================
  // Command byte, bits after the start bit, MSB first
  localparam int unsigned CMD_TAIL_BITS    = 7;
  localparam int unsigned CMD_CH_HI        = 6;
  localparam int unsigned CMD_CH_LO        = 4;
  localparam int unsigned CMD_MODE_BIT     = 3;
  localparam int unsigned CMD_SER_BIT      = 2;
  localparam int unsigned CMD_PD1_BIT      = 1;
  localparam int unsigned CMD_PD0_BIT      = 0;

  // ==========================================================
  // Counts of the command and conversion phases
  localparam logic [2:0] CMD_LAST_CNT      = 3'h6;
  localparam logic [2:0] CMD_ACQ_CNT       = 3'h3;
  localparam logic [3:0] RES12_BITS        = 4'hC;
  localparam logic [3:0] RES8_BITS         = 4'h8;

  // ==========================================================
  // Pin synchroniser
  localparam int unsigned SYNC_STAGES      = 3;
  localparam int unsigned PIN_COUNT        = 5;

  // ==========================================================
  // Reset values
  localparam logic RST_AUTO_SLEEP_SEL      = 1'b1;
  localparam logic RST_REFERENCE_ON        = 1'b0;
  localparam logic RST_PEN_ENABLE          = 1'b0;

  typedef enum logic [1:0] {
    TASV_IDLE,
    TASV_HOLD,
    TASV_SHIFT
  } tasv_phase_t;

endpackage

//--- tasv_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps

module tasv_pin_sync
  import tasv_pkg::*;
#(
  parameter int unsigned WIDTH = PIN_COUNT
)
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] rst_val,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  logic             init_q;

  // ==========================================================
  // Chain; output follows once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
        end
        else if (!init_q)
        begin
          // Idle level preloaded so no false change follows reset
          s1_q[g] <= pin_in[g];
          s2_q[g] <= rst_val[g];
          s3_q[g] <= rst_val[g];
        end
        else
        begin
          s1_q[g] <= pin_in[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
        end
      end

      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          out_q[g] <= 1'b0;
        else if (!init_q)
          out_q[g] <= rst_val[g];
        else if (s2_q[g] == s3_q[g])
          out_q[g] <= s3_q[g];
      end
    end
  endgenerate

  // Idle level loaded on the first edge after release
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      init_q <= 1'b0;
    else
      init_q <= 1'b1;
  end

  assign pin_out = out_q;

endmodule

//--- tasv_sequencer.sv
// Serial command and conversion sequencer of a touch converter
`timescale 1ns/100ps
// Operation
// - After a full-power command, pen alert stays off until an auto-sleep command.
// - With auto-sleep selected, pen alert is enabled when the conversion ends.
// - Conversion ends on the falling clock edge after result bit 1 leaves.
// - Next command is taken while the result still shifts: 16 clocks each.
// - Converter stays powered while the serial clock pauses mid-conversion.
// - Back-to-back 12-bit conversions work at 15 clocks each.
// - Results are unsigned straight binary.
// - 8-bit mode ends four clocks sooner, shifting out eight bits only.
// - Chip select high powers the converter down and abandons the conversion.
// - Reference stays on across chip select high; only a command clears it.
// - After power-up stay full power until an auto-sleep command arrives.
// - Auto-sleep bit high means full power, low means sleep between conversions.
// - Ignore input until the first high bit; then take seven command bits.
// - Mode bit low selects 12-bit, high selects 8-bit conversion.
// - 12-bit conversion over 12 clocks; ratiometric keeps drivers one clock longer.
// - Reference setting is latched as busy rises.

module tasv_sequencer
  import tasv_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       serial_conv_clock,
  input  wire logic       din,
  input  wire logic       pen_touch_n,
  input  wire logic       sar_cmp,
  output logic            dout,
  output logic            dout_oe,
  output logic            busy,
  output logic            busy_oe,
  output logic            touch_alert_n,
  output logic [2:0]      channel_sel,
  output logic            ref_single_ended_sel,
  output logic            eight_bit_sel,
  output logic            auto_sleep_sel,
  output logic            reference_on_sel,
  output logic            adc_powered,
  output logic            sample_acquire,
  output logic            touch_drivers_on,
  output logic [3:0]      sar_bit_idx
);

  logic [PIN_COUNT-1:0] pins_s;
  logic                 cs_n_s;
  logic                 sclk_s;
  logic                 din_s;
  logic                 pen_n_s;
  logic                 cmp_s;
  logic                 sclk_prev_q;
  logic                 rise;
  logic                 fall;

  tasv_phase_t          phase_q;
  logic                 hunting_q;
  logic [2:0]           cmd_cnt_q;
  logic [5:0]           cmd_sr_q;
  logic [6:0]           cmd_pend_q;
  logic                 cmd_ready_q;
  logic [3:0]           bits_left_q;
  logic                 bit_q;
  logic                 dout_q;
  logic                 acquire_q;
  logic                 tail_q;
  logic [2:0]           channel_q;
  logic                 ser_q;
  logic                 mode_q;
  logic                 auto_sleep_q;
  logic                 ref_on_q;
  logic                 pen_en_q;

  // ==========================================================
  // Pin synchronisers and clock edge detection
  tasv_pin_sync #(
    .WIDTH   (PIN_COUNT)
  ) u_sync (
    .mclk    (mclk),
    .rst     (rst),
    .pin_in  ({sar_cmp, pen_touch_n, din, serial_conv_clock, cs_n}),
    .rst_val (5'h0B),
    .pin_out (pins_s)
  );

  assign cs_n_s  = pins_s[0];
  assign sclk_s  = pins_s[1];
  assign din_s   = pins_s[2];
  assign pen_n_s = pins_s[3];
  assign cmp_s   = pins_s[4];

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sclk_prev_q <= 1'b0;
    else
      sclk_prev_q <= sclk_s;
  end

  assign rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign fall = ~sclk_s & sclk_prev_q & ~cs_n_s;

  // ==========================================================
  // Command capture, runs beside any conversion
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      hunting_q  <= 1'b1;
      cmd_cnt_q  <= 3'h0;
      cmd_sr_q   <= 6'h00;
      cmd_pend_q <= 7'h00;
      acquire_q  <= 1'b0;
    end
    else if (cs_n_s)
    begin
      hunting_q <= 1'b1;
      cmd_cnt_q <= 3'h0;
      acquire_q <= 1'b0;
    end
    else if (rise)
    begin
      if (hunting_q)
      begin
        if (din_s)
        begin
          hunting_q <= 1'b0;
          cmd_cnt_q <= 3'h0;
        end
      end
      else
      begin
        cmd_sr_q  <= {cmd_sr_q[4:0], din_s};
        cmd_cnt_q <= cmd_cnt_q + 3'h1;
        if (cmd_cnt_q == CMD_ACQ_CNT)
          acquire_q <= 1'b1;
        if (cmd_cnt_q == CMD_LAST_CNT)
        begin
          cmd_pend_q <= {cmd_sr_q, din_s};
          hunting_q  <= 1'b1;
        end
      end
    end
    else if (fall && cmd_ready_q)
      acquire_q <= 1'b0;
  end

  // Pending command flag, set wins over the take
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cmd_ready_q <= 1'b0;
    else if (cs_n_s)
      cmd_ready_q <= 1'b0;
    else if (rise && !hunting_q && cmd_cnt_q == CMD_LAST_CNT)
      cmd_ready_q <= 1'b1;
    else if (fall)
      cmd_ready_q <= 1'b0;
  end

  // ==========================================================
  // Conversion phases and result shifting
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      phase_q     <= TASV_IDLE;
      bits_left_q <= 4'h0;
      bit_q       <= 1'b0;
      dout_q      <= 1'b0;
      tail_q      <= 1'b0;
    end
    else if (cs_n_s)
    begin
      phase_q     <= TASV_IDLE;
      bits_left_q <= 4'h0;
      dout_q      <= 1'b0;
      tail_q      <= 1'b0;
    end
    else if (rise)
    begin
      if (phase_q != TASV_IDLE && bits_left_q != 4'h0)
        bit_q <= cmp_s;
    end
    else if (fall)
    begin
      tail_q <= 1'b0;
      if (phase_q == TASV_SHIFT && bits_left_q != 4'h0)
        dout_q <= bit_q;
      else
        dout_q <= 1'b0;
      if (cmd_ready_q)
      begin
        phase_q     <= TASV_HOLD;
        bits_left_q <= cmd_pend_q[CMD_MODE_BIT] ? RES8_BITS : RES12_BITS;
      end
      else
      begin
        case (phase_q)
          TASV_HOLD:
          begin
            phase_q     <= TASV_SHIFT;
            dout_q      <= bit_q;
            bits_left_q <= bits_left_q - 4'h1;
          end
          TASV_SHIFT:
          begin
            bits_left_q <= bits_left_q - 4'h1;
            if (bits_left_q == 4'h1)
            begin
              phase_q <= TASV_IDLE;
              tail_q  <= ~ser_q;
            end
          end
          default:
            phase_q <= TASV_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Configuration latched as busy rises
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      channel_q    <= 3'h0;
      ser_q        <= 1'b1;
      mode_q       <= 1'b0;
      auto_sleep_q <= RST_AUTO_SLEEP_SEL;
      ref_on_q     <= RST_REFERENCE_ON;
    end
    else if (fall && cmd_ready_q)
    begin
      channel_q    <= cmd_pend_q[CMD_CH_HI:CMD_CH_LO];
      ser_q        <= cmd_pend_q[CMD_SER_BIT];
      mode_q       <= cmd_pend_q[CMD_MODE_BIT];
      auto_sleep_q <= cmd_pend_q[CMD_PD0_BIT];
      ref_on_q     <= cmd_pend_q[CMD_PD1_BIT];
    end
  end

  // Pen alert enable
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pen_en_q <= RST_PEN_ENABLE;
    else if (fall && cmd_ready_q)
      pen_en_q <= 1'b0;
    else if (fall && phase_q == TASV_SHIFT && bits_left_q == 4'h1)
      pen_en_q <= ~auto_sleep_q;
  end

  // ==========================================================
  // Outputs
  assign busy    = (phase_q == TASV_HOLD);
  assign busy_oe = ~cs_n_s;
  assign dout    = dout_q;
  assign dout_oe = ~cs_n_s;

  assign touch_alert_n        = pen_en_q ? pen_n_s : 1'b1;
  assign channel_sel          = channel_q;
  assign ref_single_ended_sel = ser_q;
  assign eight_bit_sel        = mode_q;
  assign auto_sleep_sel       = auto_sleep_q;
  assign reference_on_sel     = ref_on_q;
  assign sample_acquire       = acquire_q;
  assign sar_bit_idx          = (bits_left_q == 4'h0) ? 4'h0 : bits_left_q - 4'h1;

  // Stays up across clock pauses; only chip select or auto-sleep drops it
  assign adc_powered = ~cs_n_s & (auto_sleep_q | acquire_q | (phase_q != TASV_IDLE));
  assign touch_drivers_on = acquire_q | tail_q
                          | (~ser_q & (phase_q != TASV_IDLE));

endmodule

//--- tasv_chk.sv
// Assertion checker of the touch converter serial sequencer
`timescale 1ns/100ps
module tasv_chk (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       dout_oe,
  input wire logic       busy,
  input wire logic       busy_oe,
  input wire logic       touch_alert_n,
  input wire logic [2:0] channel_sel,
  input wire logic       eight_bit_sel,
  input wire logic       auto_sleep_sel,
  input wire logic       reference_on_sel,
  input wire logic       adc_powered
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ====================
  // Properties
  AST_OE_OFF: assert property (cs_n [*5] |-> !dout_oe)
    else $error("dout enabled while deselected");
  AST_OE_PAIR: assert property (busy_oe == dout_oe)
    else $error("busy and dout enables differ");
  AST_CS_SLEEP: assert property (cs_n [*5] |-> !adc_powered && !busy)
    else $error("converter active while deselected");
  AST_REF_KEEP: assert property (cs_n [*5] |=> $stable(reference_on_sel))
    else $error("reference changed while deselected");
  AST_REF_LATCH: assert property ($changed(reference_on_sel) |-> $rose(busy))
    else $error("reference changed off busy rise");
  AST_MODE_LATCH: assert property
    ($changed(eight_bit_sel) || $changed(channel_sel) |-> $rose(busy))
    else $error("config changed off busy rise");
  AST_PEN_FULL: assert property (!touch_alert_n |-> !auto_sleep_sel)
    else $error("pen alert while full power");
  AST_PEN_BUSY: assert property (busy |-> touch_alert_n)
    else $error("pen alert during conversion");
  AST_FULL_POWER: assert property
    ((!cs_n && auto_sleep_sel) [*5] |-> adc_powered)
    else $error("converter off in full power");
  C_CONV: cover property ($rose(busy));
  C_PEN: cover property (!touch_alert_n);
  C_EIGHT: cover property ($rose(eight_bit_sel));
endmodule

bind tasv_sequencer tasv_chk u_chk (.mclk, .rst, .cs_n, .dout_oe, .busy, .busy_oe,
  .touch_alert_n, .channel_sel, .eight_bit_sel, .auto_sleep_sel, .reference_on_sel,
  .adc_powered);

//--- tasv_host.sv
// Host serial master model of the converter link
`timescale 1ns/100ps
module tasv_host (
  input  wire logic mclk,
  output logic      cs_n,
  output logic      serial_conv_clock,
  output logic      din,
  output logic      sar_cmp,
  input  wire logic dout
);
  localparam int HALF = 8;
  initial
  begin
    cs_n = 1'b1;
    serial_conv_clock = 1'b0;
    din = 1'b0;
    sar_cmp = 1'b0;
  end
  // ====================
  // Frame of n clocks, vectors used from bit n-1 down; clock rests low after
  task automatic frame(input int n, input logic [63:0] di, sc, output logic [63:0] dq);
    dq = '0;
    @(negedge mclk) cs_n <= 1'b0;
    repeat (HALF) @(negedge mclk);
    for (int i = n - 1; i >= 0; i--)
    begin
      din <= di[i];
      sar_cmp <= sc[i];
      serial_conv_clock <= 1'b0;
      repeat (HALF) @(negedge mclk);
      dq[i] = dout;
      serial_conv_clock <= 1'b1;
      repeat (HALF) @(negedge mclk);
    end
    serial_conv_clock <= 1'b0;
    repeat (2 * HALF) @(negedge mclk);
  endtask
  // Released data line shows the inverse level
  task automatic drop_cs;
    @(negedge mclk) cs_n <= 1'b1;
    din <= ~din;
    repeat (HALF) @(negedge mclk);
  endtask
endmodule

//--- tasv_sequencer_tb.sv
// Testbench of the touch converter serial sequencer
`timescale 1ns/100ps
module tasv_sequencer_tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        pen_touch_n = 1'b0;
  logic        cs_n, serial_conv_clock, din, sar_cmp, dout, dout_oe, busy, busy_oe;
  logic        touch_alert_n, ref_single_ended_sel, eight_bit_sel, auto_sleep_sel;
  logic        reference_on_sel, adc_powered, sample_acquire, touch_drivers_on;
  logic [3:0]  sar_bit_idx;
  logic [2:0]  channel_sel;
  logic [63:0] di, sc, dq;
  int          n, num_errors = 0, tests_run = 0;
  wire [7:0]   st = {channel_sel, eight_bit_sel, auto_sleep_sel, reference_on_sel,
                     adc_powered, touch_alert_n};
  always #25 mclk = ~mclk;
  tasv_sequencer dut (.mclk, .rst, .cs_n, .serial_conv_clock, .din, .pen_touch_n,
    .sar_cmp, .dout, .dout_oe, .busy, .busy_oe, .touch_alert_n, .channel_sel,
    .ref_single_ended_sel, .eight_bit_sel, .auto_sleep_sel, .reference_on_sel,
    .adc_powered, .sample_acquire, .touch_drivers_on, .sar_bit_idx);
  tasv_host host (.mclk, .cs_n, .serial_conv_clock, .din, .sar_cmp, .dout);
  // ====================
  // Checking and transfer tasks
  task automatic print_verdict;
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [11:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic put(input int c0, input logic [7:0] cmd, input logic [11:0] pat);
    int w;
    w = cmd[3] ? 8 : 12;
    for (int j = 0; j < 8; j++) di[n-1-c0-j] = cmd[7-j];
    for (int j = 0; j < w; j++) sc[n-8-c0-w+j] = pat[j];
  endtask
  task automatic res(input int c0, input logic [7:0] cmd, input logic [11:0] pat);
    int w;
    logic [11:0] got;
    w = cmd[3] ? 8 : 12;
    got = '0;
    for (int j = 0; j < w; j++) got[j] = dq[n-9-c0-w+j];
    cmp(got, cmd[3] ? {4'h0, pat[7:0]} : pat);
    cmp({11'h0, dq[n-10-c0-w]}, 12'h000);
  endtask
  task automatic one(input logic [7:0] cmd, input logic [11:0] pat);
    n = 26;
    di = '0;
    sc = '0;
    put(2, cmd, pat);
    host.frame(n, di, sc, dq);
    res(2, cmd, pat);
  endtask
  task automatic two(input int c1, input logic [7:0] ca, cb, input logic [11:0] pa, pb);
    n = 40;
    di = '0;
    sc = '0;
    put(0, ca, pa);
    put(c1, cb, pb);
    host.frame(n, di, sc, dq);
    res(0, ca, pa);
    res(c1, cb, pb);
  endtask
  // ====================
  // Main sequence
  initial
  begin
    repeat (16) @(negedge mclk);
    rst <= 1'b0;
    repeat (8) @(negedge mclk);
    cmp({11'h0, touch_alert_n}, 12'h001);
    one(8'h97, 12'hA5C);
    cmp({4'h0, st}, 12'h02F);
    host.drop_cs();
    cmp({9'h0, reference_on_sel, dout_oe, busy_oe}, 12'h004);
    one(8'hDC, 12'h096);
    cmp({4'h0, st}, 12'h0B0);
    two(16, 8'hD3, 8'hA7, 12'h3C9, 12'hF0E);
    cmp({4'h0, st}, 12'h04F);
    two(15, 8'hB4, 8'hE5, 12'h5A3, 12'h0FF);
    cmp({4'h0, st}, 12'h0CB);
    n = 12;
    di = {52'h0, 8'hD0, 4'h0};
    sc = '0;
    host.frame(n, di, sc, dq);
    repeat (40) @(negedge mclk);
    cmp({11'h0, adc_powered}, 12'h001);
    cmp({5'h0, sample_acquire, ref_single_ended_sel, touch_drivers_on, sar_bit_idx}, 12'h017);
    host.drop_cs();
    cmp({5'h0, st[7:1]}, 12'h050);
    cmp({10'h0, dout_oe, busy}, 12'h000);
    one(8'h97, 12'h6B1);
    print_verdict();
  end
  initial
  begin
    repeat (30000) @(posedge mclk);
    num_errors++;
    print_verdict();
  end
endmodule
